/* logic/qsm_pkg.sv */
// Purpose: Shared constants for the quad serial master command and pin block
// Assumes: APB with 32-bit data, byte addresses, one register per aligned word
// Notes:   Offsets, field positions, reset values and engine states live here
package qsm_pkg;

    // Register byte offsets
    localparam logic [7:0] QSM_OFS_CTRL = 8'h04;
    localparam logic [7:0] QSM_OFS_CMD  = 8'h08;
    localparam logic [7:0] QSM_OFS_PIN  = 8'h0c;
    localparam logic [7:0] QSM_OFS_STAT = 8'h10;
    localparam logic [7:0] QSM_OFS_CNT  = 8'h14;
    localparam logic [7:0] QSM_OFS_TXD  = 8'h20;
    localparam logic [7:0] QSM_OFS_RXD  = 8'h24;

    // transfer_command bits, write only, read as zero
    localparam int QSM_CMD_START = 0;
    localparam int QSM_CMD_STOP  = 1;
    localparam int QSM_CMD_FLUSH = 2;

    // pin_drive_control bits and reset value
    localparam int QSM_PIN_TX_PU   = 7;
    localparam int QSM_PIN_TX_PD   = 6;
    localparam int QSM_PIN_RX_PU   = 5;
    localparam int QSM_PIN_RX_PD   = 4;
    localparam int QSM_PIN_HOLD_OE = 3;
    localparam int QSM_PIN_HOLD_V  = 2;
    localparam int QSM_PIN_WP_OE   = 1;
    localparam int QSM_PIN_WP_V    = 0;
    localparam logic [7:0] QSM_PIN_RST = 8'h25;

    // Control word fields and reset value
    localparam int QSM_CTRL_MODE_LSB = 0;
    localparam int QSM_CTRL_TXM_LSB  = 2;
    localparam int QSM_CTRL_RXEN     = 6;
    localparam int QSM_CTRL_LEN_LSB  = 16;
    localparam logic [31:0] QSM_CTRL_MASK = 32'h00ff_004f;
    localparam logic [31:0] QSM_CTRL_RST  = 32'h0000_0000;

    // Status and count fields
    localparam int QSM_STAT_ACTIVE = 16;
    localparam int QSM_STAT_RXE    = 13;
    localparam int QSM_STAT_RXF    = 12;
    localparam int QSM_STAT_TXE    = 9;
    localparam int QSM_STAT_TXF    = 8;
    localparam int QSM_CNT_RX_LSB  = 8;

    // Interface modes and transmit modes
    localparam logic [1:0] QSM_MODE_SINGLE = 2'h0;
    localparam logic [1:0] QSM_MODE_DUAL   = 2'h1;
    localparam logic [1:0] QSM_MODE_QUAD   = 2'h2;
    localparam logic [1:0] QSM_TXM_OFF     = 2'h0;
    localparam logic [1:0] QSM_TXM_FIFO    = 2'h1;
    localparam logic [1:0] QSM_TXM_ZERO    = 2'h2;
    localparam logic [1:0] QSM_TXM_ONES    = 2'h3;

    // Data path sizes
    localparam int QSM_DATA_W     = 8;
    localparam int QSM_FIFO_DEPTH = 16;
    localparam logic [3:0] QSM_BYTE_BITS = 4'h8;

    typedef enum logic [1:0] {
        QSM_IDLE  = 2'b00,
        QSM_LOAD  = 2'b01,
        QSM_SHIFT = 2'b10,
        QSM_STORE = 2'b11
    } qsm_state_e;

endpackage

/* logic/qsm_fifo.sv */
// Purpose: Synchronous FIFO with valid/ready on both sides and a flush
// Assumes: DEPTH is a power of two, one clock, synchronous active-low reset
// Notes:   Flush wins over a push or pop in the same cycle
`timescale 1ns/100ps
`default_nettype none
module qsm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                       clock_in,
    input  wire logic                       rst_n_in,
    input  wire logic                       flush_in,
    input  wire logic                       in_valid_in,
    input  wire logic [WIDTH-1:0]           in_data_in,
    output logic                            in_ready_out,
    output logic                            out_valid_out,
    output logic [WIDTH-1:0]                out_data_out,
    input  wire logic                       out_ready_in,
    output logic [$clog2(DEPTH):0]          count_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } qsm_fifo_s;

    qsm_fifo_s q, d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // Refuse depths the pointer arithmetic cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("qsm_fifo: DEPTH must be a power of two >= 2");
    end

    // Extra pointer bit tells full from empty without a separate flag
    assign count_out     = q.wp - q.rp;
    assign in_ready_out  = count_out != (AW+1)'(DEPTH);
    assign out_valid_out = count_out != '0;
    assign out_data_out  = mem[q.rp[AW-1:0]];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_ready_in & out_valid_out;

    always_comb begin
        d = q;
        if (flush_in) begin
            d.wp = q.rp;
        end else begin
            if (push) begin
                d.wp = q.wp + 1'b1;
            end
            if (pop) begin
                d.rp = q.rp + 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Storage needs no reset; only the pointers say what is valid
    always_ff @(posedge clock_in) begin
        if (push && !flush_in) begin
            mem[q.wp[AW-1:0]] <= in_data_in;
        end
    end
endmodule // qsm_fifo
`default_nettype wire

/* logic/qsm_exec_ctrl.sv */
// Purpose: Command, pin control and byte engine of a quad serial master
// Assumes: APB slave on clock_in; link clock arrives as a plain input
// Notes:   Function
// Function
// - Flush command empties both FIFOs, zeroes counts
// - Stop ends transfer at next byte boundary
// - Start begins transfer with current control settings
// - Zero command bits ignored; command bits self-clear
// - Transmit pull-ups while transmit pins undriven
// - Transmit pull-downs while transmit pins undriven
// - Receive pull-ups while deselected; resets set
// - Receive pull-downs while chip select deasserted
// - Hold pin driven only when enable set
// - Driven hold level follows value bit, resets one
// - Write-protect pin driven only when enabled
// - Driven write-protect level follows value bit
// - Transmit off leaves data lines undriven
`timescale 1ns/100ps
`default_nettype none
module qsm_exec_ctrl
    import qsm_pkg::*;
#(
    parameter int FIFO_DEPTH = QSM_FIFO_DEPTH
) (
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        link_clk_in,
    input  wire logic [3:0]  io_in,
    output logic      [3:0]  io_out,
    output logic      [3:0]  io_oe_out,
    output logic             sclk_out,
    output logic             cs_n_out,
    output logic      [3:0]  tx_pu_out,
    output logic      [3:0]  tx_pd_out,
    output logic             rx_pu_out,
    output logic             rx_pd_out,
    output logic             hold_out,
    output logic             hold_oe_out,
    output logic             wp_out,
    output logic             wp_oe_out
);
    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    // Count fields are eight bits wide in the count register
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128) begin : g_chk
        $error("qsm_exec_ctrl: FIFO_DEPTH must lie in 2..128");
    end

    typedef struct packed {
        qsm_state_e  st;
        logic [31:0] ctrl;
        logic [7:0]  pin;
        logic [4:0]  sy1;
        logic [4:0]  sy2;
        logic [4:0]  sy3;
        logic        lvl;
        logic [3:0]  iv;
        logic [7:0]  txsh;
        logic [7:0]  rxsh;
        logic [3:0]  bitc;
        logic [7:0]  bytec;
        logic        stop_pend;
        logic        sclk;
        logic        cs_n;
        logic [3:0]  io;
        logic [3:0]  io_oe;
        logic [3:0]  tx_pu;
        logic [3:0]  tx_pd;
        logic        rx_pu;
        logic        rx_pd;
        logic        hold;
        logic        hold_oe;
        logic        wp;
        logic        wp_oe;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } qsm_ctrl_s;

    // Reset image: deselected, pins undriven, receive pull-up on
    localparam qsm_ctrl_s ST_RST = '{
        st:     QSM_IDLE,
        ctrl:   QSM_CTRL_RST,
        pin:    QSM_PIN_RST,
        cs_n:   1'b1,
        rx_pu:  QSM_PIN_RST[QSM_PIN_RX_PU],
        hold:   QSM_PIN_RST[QSM_PIN_HOLD_V],
        wp:     QSM_PIN_RST[QSM_PIN_WP_V],
        default: '0
    };

    qsm_ctrl_s q, d;

    // FIFO handshakes
    logic            fifo_flush;
    logic            tx_push;
    logic            tx_in_ready;
    logic            tx_valid;
    logic [7:0]      tx_data;
    logic            tx_pop;
    logic [CW-1:0]   tx_cnt;
    logic            rx_push;
    logic            rx_in_ready;
    logic            rx_valid;
    logic [7:0]      rx_data;
    logic            rx_pop;
    logic [CW-1:0]   rx_cnt;

    // Bits moved per link clock for a given interface mode
    function automatic logic [3:0] lanes(input logic [1:0] mode);
        case (mode)
            QSM_MODE_DUAL: lanes = 4'h2;
            QSM_MODE_QUAD: lanes = 4'h4;
            default:       lanes = 4'h1;
        endcase
    endfunction

    // Whether an address hits any register
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == QSM_OFS_CTRL) || (a == QSM_OFS_CMD) ||
                 (a == QSM_OFS_PIN) || (a == QSM_OFS_STAT) ||
                 (a == QSM_OFS_CNT) || (a == QSM_OFS_TXD) ||
                 (a == QSM_OFS_RXD);
    endfunction

    qsm_fifo #(
        .WIDTH (QSM_DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .flush_in      (fifo_flush),
        .in_valid_in   (tx_push),
        .in_data_in    (pwdata_in[7:0]),
        .in_ready_out  (tx_in_ready),
        .out_valid_out (tx_valid),
        .out_data_out  (tx_data),
        .out_ready_in  (tx_pop),
        .count_out     (tx_cnt)
    );

    qsm_fifo #(
        .WIDTH (QSM_DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .flush_in      (fifo_flush),
        .in_valid_in   (rx_push),
        .in_data_in    (q.rxsh),
        .in_ready_out  (rx_in_ready),
        .out_valid_out (rx_valid),
        .out_data_out  (rx_data),
        .out_ready_in  (rx_pop),
        .count_out     (rx_cnt)
    );

    // Whole next-state computation
    always_comb begin
        logic        acc;
        logic        done;
        logic        wr;
        logic        cmd_wr;
        logic        do_start;
        logic        do_stop;
        logic        lk_ok;
        logic        rise;
        logic        fall;
        logic [1:0]  mode;
        logic [1:0]  txm;
        logic        rx_en;
        logic [7:0]  len;
        logic [3:0]  n;
        logic [3:0]  nbits;
        logic        tx_on;
        logic        active;
        logic [31:0] rv;
        acc      = 1'b0;
        done     = 1'b0;
        wr       = 1'b0;
        cmd_wr   = 1'b0;
        do_start = 1'b0;
        do_stop  = 1'b0;
        lk_ok    = 1'b0;
        rise     = 1'b0;
        fall     = 1'b0;
        mode     = q.ctrl[QSM_CTRL_MODE_LSB +: 2];
        txm      = q.ctrl[QSM_CTRL_TXM_LSB +: 2];
        rx_en    = q.ctrl[QSM_CTRL_RXEN];
        len      = q.ctrl[QSM_CTRL_LEN_LSB +: 8];
        n        = lanes(mode);
        nbits    = q.bitc + n;
        tx_on    = 1'b0;
        active   = 1'b0;
        rv       = '0;
        d        = q;
        fifo_flush = 1'b0;
        tx_push  = 1'b0;
        tx_pop   = 1'b0;
        rx_push  = 1'b0;
        rx_pop   = 1'b0;

        // Three-stage sampling; a change counts once stages two and three agree
        d.sy1 = {link_clk_in, io_in};
        d.sy2 = q.sy1;
        d.sy3 = q.sy2;
        lk_ok = q.sy2[4] == q.sy3[4];
        if (lk_ok) begin
            d.lvl = q.sy3[4];
        end
        rise = lk_ok & q.sy3[4] & ~q.lvl;
        fall = lk_ok & ~q.sy3[4] & q.lvl;
        for (int i = 0; i < 4; i++) begin
            if (q.sy2[i] == q.sy3[i]) begin
                d.iv[i] = q.sy3[i];
            end
        end

        // APB: one wait state, then pready for a single cycle
        acc  = psel_in & penable_in;
        done = acc & q.pready;
        wr   = done & pwrite_in;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        d.prdata  = '0;
        case (paddr_in)
            QSM_OFS_CTRL: rv = q.ctrl;
            QSM_OFS_PIN:  rv = {24'h0, q.pin};
            QSM_OFS_STAT: begin
                rv[QSM_STAT_ACTIVE] = q.st != QSM_IDLE;
                rv[QSM_STAT_RXE]    = ~rx_valid;
                rv[QSM_STAT_RXF]    = ~rx_in_ready;
                rv[QSM_STAT_TXE]    = ~tx_valid;
                rv[QSM_STAT_TXF]    = ~tx_in_ready;
            end
            QSM_OFS_CNT:  rv = (32'(rx_cnt) << QSM_CNT_RX_LSB) | 32'(tx_cnt);
            QSM_OFS_RXD:  rv = rx_valid ? {24'h0, rx_data} : 32'h0;
            default:      rv = '0;
        endcase
        // A data write to a full transmit FIFO waits here: back-pressure to the bus
        if (acc && !q.pready &&
            !(pwrite_in && paddr_in == QSM_OFS_TXD && !tx_in_ready)) begin
            d.pready  = 1'b1;
            d.pslverr = ~mapped(paddr_in);
            d.prdata  = pwrite_in ? 32'h0 : rv;
        end

        // Write and pop effects happen only at the completing edge
        if (wr && paddr_in == QSM_OFS_CTRL) begin
            d.ctrl = pwdata_in & QSM_CTRL_MASK;
        end
        if (wr && paddr_in == QSM_OFS_PIN) begin
            d.pin = pwdata_in[7:0];
        end
        tx_push = wr && paddr_in == QSM_OFS_TXD;
        rx_pop  = done && !pwrite_in && paddr_in == QSM_OFS_RXD && rx_valid;
        cmd_wr  = wr && paddr_in == QSM_OFS_CMD;
        // Command bits are pulses, never stored, so zeros do nothing
        fifo_flush = cmd_wr & pwdata_in[QSM_CMD_FLUSH];
        do_stop    = cmd_wr & pwdata_in[QSM_CMD_STOP];
        do_start   = cmd_wr & pwdata_in[QSM_CMD_START] &
                     ~pwdata_in[QSM_CMD_STOP];

        // Byte engine
        case (q.st)
            QSM_IDLE: begin
                d.stop_pend = 1'b0;
                d.sclk      = 1'b0;
                if (do_start) begin
                    d.st    = QSM_LOAD;
                    d.cs_n  = 1'b0;
                    d.bytec = '0;
                end
            end
            QSM_LOAD: begin
                // Only byte boundaries land here, so stop never cuts a byte
                if (q.stop_pend || (len != '0 && q.bytec == len)) begin
                    d.st        = QSM_IDLE;
                    d.cs_n      = 1'b1;
                    d.stop_pend = 1'b0;
                end else begin
                    d.bitc = '0;
                    case (txm)
                        QSM_TXM_FIFO: begin
                            if (tx_valid) begin
                                d.txsh = tx_data;
                                tx_pop = 1'b1;
                                d.st   = QSM_SHIFT;
                            end
                        end
                        QSM_TXM_ONES: begin
                            d.txsh = 8'hff;
                            d.st   = QSM_SHIFT;
                        end
                        default: begin
                            d.txsh = 8'h00;
                            d.st   = QSM_SHIFT;
                        end
                    endcase
                end
            end
            QSM_SHIFT: begin
                // Capture on the fall: data lanes lag the clock by as many stages
                if (rise && !q.sclk) begin
                    d.sclk = 1'b1;
                end else if (fall && q.sclk) begin
                    d.sclk = 1'b0;
                    case (mode)
                        QSM_MODE_DUAL: d.rxsh = {q.rxsh[5:0], q.iv[1:0]};
                        QSM_MODE_QUAD: d.rxsh = {q.rxsh[3:0], q.iv};
                        default:       d.rxsh = {q.rxsh[6:0], q.iv[1]};
                    endcase
                    d.txsh = q.txsh << n;
                    d.bitc = nbits;
                    if (nbits == QSM_BYTE_BITS) begin
                        d.st = QSM_STORE;
                    end
                end
            end
            QSM_STORE: begin
                // A full receive FIFO holds the clock low until space appears
                rx_push = rx_en;
                if (!rx_en || rx_in_ready) begin
                    d.bytec = q.bytec + 8'h01;
                    d.st    = QSM_LOAD;
                end
            end
            default: begin
                d.st   = QSM_IDLE;
                d.cs_n = 1'b1;
            end
        endcase

        // A stop while busy is held until the next byte boundary
        if (do_stop && d.st != QSM_IDLE) begin
            d.stop_pend = 1'b1;
        end

        // Data lane drive
        case (mode)
            QSM_MODE_DUAL: d.io = {2'b00, d.txsh[7:6]};
            QSM_MODE_QUAD: d.io = d.txsh[7:4];
            default:       d.io = {3'b000, d.txsh[7]};
        endcase
        active = d.st != QSM_IDLE;
        tx_on  = active && txm != QSM_TXM_OFF;
        // Dual and quad need one direction off, so lanes float unless sending
        case (mode)
            QSM_MODE_DUAL: d.io_oe = {2'b00, {2{tx_on}}};
            QSM_MODE_QUAD: d.io_oe = {4{tx_on}};
            default:       d.io_oe = {3'b000, tx_on};
        endcase

        // Pulls are registered from the next drive state, so they change with it, as all outputs do
        d.tx_pu = {4{d.pin[QSM_PIN_TX_PU]}} & ~d.io_oe;
        d.tx_pd = {4{d.pin[QSM_PIN_TX_PD]}} & ~d.io_oe;
        d.rx_pu = d.pin[QSM_PIN_RX_PU] & d.cs_n;
        d.rx_pd = d.pin[QSM_PIN_RX_PD] & d.cs_n;
        d.hold_oe = d.pin[QSM_PIN_HOLD_OE];
        d.hold    = d.pin[QSM_PIN_HOLD_V];
        d.wp_oe   = d.pin[QSM_PIN_WP_OE];
        d.wp      = d.pin[QSM_PIN_WP_V];
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // Every output is a flip-flop of the state struct
    assign prdata_out  = q.prdata;
    assign pready_out  = q.pready;
    assign pslverr_out = q.pslverr;
    assign io_out      = q.io;
    assign io_oe_out   = q.io_oe;
    assign sclk_out    = q.sclk;
    assign cs_n_out    = q.cs_n;
    assign tx_pu_out   = q.tx_pu;
    assign tx_pd_out   = q.tx_pd;
    assign rx_pu_out   = q.rx_pu;
    assign rx_pd_out   = q.rx_pd;
    assign hold_out    = q.hold;
    assign hold_oe_out = q.hold_oe;
    assign wp_out      = q.wp;
    assign wp_oe_out   = q.wp_oe;
endmodule // qsm_exec_ctrl
`default_nettype wire

/* dv/qsm_exec_ctrl_monitor.sv */
// Purpose: Assertions on the bus and pin ports of qsm_exec_ctrl
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Pins take a register write at its completing edge, seen at the next sample
`timescale 1ns/100ps
`default_nettype none
module qsm_exec_ctrl_monitor
    import qsm_pkg::*;
(
    input wire logic        clock_in,
    input wire logic        rst_n_in,
    input wire logic [7:0]  paddr_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        cs_n_out,
    input wire logic [3:0]  io_oe_out,
    input wire logic [3:0]  tx_pu_out,
    input wire logic [3:0]  tx_pd_out,
    input wire logic        rx_pu_out,
    input wire logic        rx_pd_out,
    input wire logic        hold_out,
    input wire logic        hold_oe_out,
    input wire logic        wp_out,
    input wire logic        wp_oe_out
);
    logic pin_wr;
    logic done;
    // Completing edges of bus transfers
    assign done = psel_in && penable_in && pready_out;
    assign pin_wr = done && pwrite_in && paddr_in == QSM_OFS_PIN;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    sequence setup_s; psel_in && !penable_in && paddr_in != QSM_OFS_TXD; endsequence
    sequence one_wait_s; !pready_out ##1 pready_out; endsequence
    a_hold_drive_en: assert property (pin_wr |=> hold_oe_out == $past(pwdata_in[3]))
        else $error("hold enable does not follow its bit");
    a_hold_drive_lvl: assert property (pin_wr ##1 hold_oe_out |-> hold_out == $past(pwdata_in[2]))
        else $error("hold level does not follow its bit");
    a_wp_drive_en: assert property (pin_wr |=> wp_oe_out == $past(pwdata_in[1]))
        else $error("write-protect enable does not follow its bit");
    a_wp_drive_lvl: assert property (pin_wr ##1 wp_oe_out |-> wp_out == $past(pwdata_in[0]))
        else $error("write-protect level does not follow its bit");
    a_pin_en_hold: assert property (!$past(pin_wr) |-> $stable(hold_oe_out) && $stable(wp_oe_out))
        else $error("drive enable changed without a write");
    a_rx_pull_sel: assert property (!cs_n_out && $past(cs_n_out) == 1'b0 |-> !rx_pu_out && !rx_pd_out)
        else $error("receive pull on while selected");
    a_tx_pull_drv: assert property (((tx_pu_out | tx_pd_out) & io_oe_out & $past(io_oe_out)) == 4'h0)
        else $error("transmit pull on a driven line");
    a_idle_no_drive: assert property (cs_n_out && $past(cs_n_out) |-> io_oe_out == 4'h0)
        else $error("data line driven while deselected");
    a_cmd_read_zero: assert property (done && !pwrite_in && paddr_in == QSM_OFS_CMD |-> prdata_out == 32'h0)
        else $error("command register holds a one");
    a_apb_one_wait: assert property (setup_s |=> one_wait_s)
        else $error("ready not after one wait state");
endmodule // qsm_exec_ctrl_monitor
bind qsm_exec_ctrl qsm_exec_ctrl_monitor qsm_exec_ctrl_monitor_i (.clock_in, .rst_n_in, .paddr_in,
    .psel_in, .penable_in, .pwrite_in, .pwdata_in, .prdata_out, .pready_out, .cs_n_out, .io_oe_out,
    .tx_pu_out, .tx_pd_out, .rx_pu_out, .rx_pd_out, .hold_out, .hold_oe_out, .wp_out, .wp_oe_out);
`default_nettype wire

/* dv/qsm_flash_model.sv */
// Purpose: Serial flash stand-in that answers one fixed byte
// Assumes: Samples on clock rise, shifts on clock fall
// Notes:   A released data line shows the inverse of its last level
`timescale 1ns/100ps
`default_nettype none
module qsm_flash_model (
    input  wire logic       cs_n_in,
    input  wire logic       sclk_in,
    input  wire logic       mosi_in,
    input  wire logic [7:0] reply_in,
    output logic            miso_out,
    output logic [7:0]      got_out
);
    logic [7:0] shift_r = 8'h00;
    initial miso_out = 1'b0;
    initial got_out = 8'h00;
    // Load on select so bit 7 is ready before the first rise
    always @(negedge cs_n_in) begin
        shift_r = reply_in;
        miso_out = reply_in[7];
    end
    // Capture incoming bits MSB first
    always @(posedge sclk_in) if (cs_n_in === 1'b0) got_out = {got_out[6:0], mosi_in};
    // Rotating repeats the answer for every byte
    always @(negedge sclk_in) if (cs_n_in === 1'b0) begin
        shift_r = {shift_r[6:0], shift_r[7]};
        miso_out = shift_r[7];
    end
    // No pull assumed once released, so show a level nobody may trust
    always @(posedge cs_n_in) miso_out = ~miso_out;
endmodule // qsm_flash_model
`default_nettype wire

/* dv/qsm_exec_ctrl_tb_top.sv */
// Purpose: Register-level tests of the command and pin control block
// Assumes: APB master tasks, flash stand-in on the single data lines
// Notes:   Reset held three cycles; the synchronisers reset with the design
`timescale 1ns/100ps
`default_nettype none
module qsm_exec_ctrl_tb_top;
    import qsm_pkg::*;
    logic        clock_in = 1'b0, rst_n_in = 1'b0, link_clk_in = 1'b0;
    logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00, got;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic [3:0]  io_in, io_out, io_oe_out, tx_pu_out, tx_pd_out;
    logic        pready_out, pslverr_out, sclk_out, cs_n_out, rx_pu_out, rx_pd_out;
    logic        hold_out, hold_oe_out, wp_out, wp_oe_out, miso, err;
    int          n_errors = 0, check_count = 0, n_bits = 0;
    // System clock and an unrelated link clock
    always #10 clock_in = ~clock_in;
    initial #7 forever #80 link_clk_in = ~link_clk_in;
    assign io_in = {2'b11, miso, 1'b1};
    qsm_exec_ctrl qsm_exec_ctrl_i (.clock_in, .rst_n_in, .paddr_in, .psel_in, .penable_in,
        .pwrite_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .link_clk_in, .io_in,
        .io_out, .io_oe_out, .sclk_out, .cs_n_out, .tx_pu_out, .tx_pd_out, .rx_pu_out,
        .rx_pd_out, .hold_out, .hold_oe_out, .wp_out, .wp_oe_out);
    qsm_flash_model qsm_flash_model_i (.cs_n_in(cs_n_out), .sclk_in(sclk_out),
        .mosi_in(io_out[0]), .reply_in(8'h96), .miso_out(miso), .got_out(got));
    // Bits clocked while selected
    always @(posedge sclk_out) if (cs_n_out === 1'b0) n_bits++;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One APB transfer; holds the request until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do @(posedge clock_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic pins(input logic [7:0] v);
        apb(1'b1, QSM_OFS_PIN, {24'h0, v});
        @(negedge clock_in);
        chk(32'({hold_oe_out, hold_out & v[3], wp_oe_out, wp_out & v[1]}),
            32'({v[3], v[2] & v[3], v[1], v[0] & v[1]}));
        chk(32'({tx_pu_out, tx_pd_out, rx_pu_out, rx_pd_out}),
            32'({{4{v[7]}}, {4{v[6]}}, v[5], v[4]}));
        apb(1'b0, QSM_OFS_PIN, 32'h0);
        chk(rd, {24'h0, v});
    endtask
    // Transfer ends when chip select rises again
    task automatic wait_end();
        repeat (2) @(posedge clock_in);
        while (cs_n_out !== 1'b1) @(posedge clock_in);
    endtask
    task automatic conclude();
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Watchdog well beyond the few microseconds of traffic
    initial begin
        #300us;
        n_errors++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge clock_in);
        rst_n_in <= 1'b1;
        apb(1'b0, QSM_OFS_PIN, 32'h0);
        chk(rd, 32'h25);
        chk(32'({hold_oe_out, hold_out, wp_oe_out, wp_out, rx_pu_out, rx_pd_out}), 32'h16);
        apb(1'b0, 8'h3c, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b0, QSM_OFS_CMD, 32'h0);
        chk(rd, 32'h0);
        pins(8'h00);
        pins(8'h6f);
        pins(8'h9a);
        // Two bytes from the FIFO, receive on
        apb(1'b1, QSM_OFS_CTRL, 32'h0002_0044);
        apb(1'b1, QSM_OFS_TXD, 32'ha5);
        apb(1'b1, QSM_OFS_TXD, 32'h3c);
        n_bits = 0;
        apb(1'b1, QSM_OFS_CMD, 32'h1);
        wait_end();
        chk(32'(n_bits), 32'd16);
        chk(32'(got), 32'h3c);
        apb(1'b0, QSM_OFS_RXD, 32'h0);
        chk(rd, 32'h96);
        // Fill the transmit FIFO until full, then flush both
        for (int i = 0; i < QSM_FIFO_DEPTH; i++) apb(1'b1, QSM_OFS_TXD, 32'(i));
        apb(1'b0, QSM_OFS_STAT, 32'h0);
        chk(rd & 32'h0001_3300, 32'h0000_0100);
        apb(1'b0, QSM_OFS_CNT, 32'h0);
        chk(rd & 32'hffff, 32'h0110);
        apb(1'b1, QSM_OFS_CMD, 32'h4);
        apb(1'b0, QSM_OFS_CNT, 32'h0);
        chk(rd & 32'hffff, 32'h0);
        apb(1'b0, QSM_OFS_RXD, 32'h0);
        chk(rd, 32'h0);
        // Zero write and start with stop must not begin a transfer
        apb(1'b1, QSM_OFS_CTRL, 32'h0000_000c);
        apb(1'b1, QSM_OFS_CMD, 32'h0);
        apb(1'b1, QSM_OFS_CMD, 32'h3);
        repeat (20) @(posedge clock_in);
        chk(32'(cs_n_out), 32'h1);
        // Endless ones transfer cut by stop in mid-byte
        n_bits = 0;
        apb(1'b1, QSM_OFS_CMD, 32'h1);
        repeat (90) @(posedge clock_in);
        chk(32'(io_oe_out), 32'h1);
        apb(1'b1, QSM_OFS_CMD, 32'h2);
        wait_end();
        chk(32'(n_bits % 8), 32'h0);
        chk(32'(n_bits > 0), 32'h1);
        chk(32'(got), 32'hff);
        conclude();
    end
endmodule // qsm_exec_ctrl_tb_top
`default_nettype wire
